// ### logic/spfc_ctrl.sv
// Self-programming flash controller with AXI4-Lite register access
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
module spfc_ctrl #(
  parameter int unsigned OP_CYC = spfc_pkg::OP_CYC
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RST,
  input  wire logic [4:0]   S_AXI_AWADDR,
  input  wire logic         S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  input  wire logic [31:0]  S_AXI_WDATA,
  input  wire logic [3:0]   S_AXI_WSTRB,
  input  wire logic         S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  wire logic         S_AXI_BREADY,
  input  wire logic [4:0]   S_AXI_ARADDR,
  input  wire logic         S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  wire logic         S_AXI_RREADY,
  input  wire logic [1:0]   WRITE_PROTECT_FIELD,
  output logic [14:0]       FLASH_ADDR,
  output logic              FLASH_RD,
  input  wire logic [13:0]  FLASH_RDATA,
  output logic              FLASH_ERASE,
  output logic              FLASH_PROG,
  output logic [447:0]      FLASH_BLOCK,
  output logic              CORE_SKIP,
  output logic              CORE_STALL
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RWAIT = 3'b001,
    ST_RACC  = 3'b010,
    ST_SETUP = 3'b011,
    ST_BUSY  = 3'b100
  } spfc_state_e;

  spfc_state_e  state_r;
  logic [7:0]   addr_low_r;
  logic [6:0]   addr_high_r;
  logic [7:0]   data_low_r;
  logic [5:0]   data_high_r;
  logic         rd_r, wr_r, write_enable_bit_r, free_r, latch_only_select_r, config_space_select_r, program_memory_select_r;
  logic [1:0]   unlock_r;
  logic [1:0]   setup_r;
  logic [31:0]  timer_r;
  logic         pulse_r;
  logic         bvalid_r, rvalid_r;
  logic [1:0]   bresp_r, rresp_r;
  logic [31:0]  rdata_r;
  logic [13:0]  latch_r [spfc_pkg::LATCH_N];
  logic         wr_acc, rd_acc, ctrl_wr, wr_req;
  logic         start_rd, start_op, start_latch, op_done;
  logic         prot;
  logic [14:0]  addr;
  logic [4:0]   lidx;

  assign addr = {addr_high_r, addr_low_r};
  assign lidx = addr_low_r[spfc_pkg::LATCH_AW-1:0];

  // Bus handshakes
  assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_r;
  assign S_AXI_WREADY  = S_AXI_AWREADY;
  assign S_AXI_ARREADY = !rvalid_r;
  assign wr_acc  = S_AXI_AWREADY && S_AXI_WSTRB[0];
  assign rd_acc  = S_AXI_ARVALID && S_AXI_ARREADY;
  assign ctrl_wr = wr_acc && S_AXI_AWADDR == spfc_pkg::OFS_CONTROL;
  assign wr_req  = ctrl_wr && S_AXI_WDATA[spfc_pkg::BIT_WR];

  // Protected segment check
  always_comb begin
    unique case (WRITE_PROTECT_FIELD)
      spfc_pkg::WP_ALL:   prot = 1'b1;
      spfc_pkg::WP_LOWER: prot = addr <= spfc_pkg::WP_LOWER_END;
      spfc_pkg::WP_BOOT:  prot = addr <= spfc_pkg::WP_BOOT_END;
      default:            prot = 1'b0;
    endcase
  end

  // Strobe qualification
  always_comb begin
    start_rd = ctrl_wr && S_AXI_WDATA[spfc_pkg::BIT_RD] &&
               state_r == ST_IDLE && program_memory_select_r && !config_space_select_r;
    start_op = wr_req && write_enable_bit_r && unlock_r == 2'd2 &&
               state_r == ST_IDLE && program_memory_select_r && !config_space_select_r &&
               !prot;
    start_latch = start_op && latch_only_select_r && !free_r;
  end

  assign op_done = state_r == ST_BUSY && timer_r == OP_CYC - 1;

  // Sequencer
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_rd) begin
            state_r <= ST_RWAIT;
          end else if (start_op && !start_latch) begin
            state_r <= ST_SETUP;
          end
        end
        ST_RWAIT: state_r <= ST_RACC;
        ST_RACC:  state_r <= ST_IDLE;
        ST_SETUP: begin
          if (setup_r == 2'(spfc_pkg::SETUP_CYC - 1)) begin
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (op_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Setup and operation timers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      setup_r <= 2'h0;
      timer_r <= 32'h0;
    end else begin
      setup_r <= (state_r == ST_SETUP) ? setup_r + 2'h1 : 2'h0;
      timer_r <= (state_r == ST_BUSY) ? timer_r + 32'h1 : 32'h0;
    end
  end

  // Flash command pulse on entry to the busy phase
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= state_r == ST_SETUP &&
                 setup_r == 2'(spfc_pkg::SETUP_CYC - 1);
    end
  end

  assign FLASH_ERASE = pulse_r && free_r;
  assign FLASH_PROG  = pulse_r && !free_r;
  assign FLASH_RD    = state_r == ST_RACC;
  assign CORE_SKIP   = state_r == ST_RACC;
  assign CORE_STALL  = state_r == ST_BUSY;
  assign FLASH_ADDR  = (FLASH_ERASE || FLASH_PROG) ?
                       {addr[14:5], 5'h00} : addr;

  // Unlock sequence tracker
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      unlock_r <= 2'd0;
    end else if (wr_acc) begin
      if (S_AXI_AWADDR != spfc_pkg::OFS_UNLOCK) begin
        unlock_r <= 2'd0;
      end else if (S_AXI_WDATA[7:0] == spfc_pkg::UNLOCK_KEY1) begin
        unlock_r <= 2'd1;
      end else if (S_AXI_WDATA[7:0] == spfc_pkg::UNLOCK_KEY2 &&
                   unlock_r == 2'd1) begin
        unlock_r <= 2'd2;
      end else begin
        unlock_r <= 2'd0;
      end
    end
  end

  // Address registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      addr_low_r  <= 8'h00;
      addr_high_r <= 7'h00;
    end else if (wr_acc) begin
      if (S_AXI_AWADDR == spfc_pkg::OFS_ADDR_LOW) begin
        addr_low_r <= S_AXI_WDATA[7:0];
      end
      if (S_AXI_AWADDR == spfc_pkg::OFS_ADDR_HIGH) begin
        addr_high_r <= S_AXI_WDATA[6:0];
      end
    end
  end

  // Data registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      data_low_r  <= 8'h00;
      data_high_r <= 6'h00;
    end else if (state_r == ST_RACC) begin
      data_low_r  <= FLASH_RDATA[7:0];
      data_high_r <= FLASH_RDATA[13:8];
    end else if (wr_acc) begin
      if (S_AXI_AWADDR == spfc_pkg::OFS_DATA_LOW) begin
        data_low_r <= S_AXI_WDATA[7:0];
      end
      if (S_AXI_AWADDR == spfc_pkg::OFS_DATA_HIGH) begin
        data_high_r <= S_AXI_WDATA[5:0];
      end
    end
  end

  // Control bits
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      write_enable_bit_r  <= 1'b0;
      latch_only_select_r  <= 1'b0;
      config_space_select_r  <= 1'b0;
      program_memory_select_r <= 1'b0;
    end else if (ctrl_wr) begin
      write_enable_bit_r  <= S_AXI_WDATA[spfc_pkg::BIT_WRITE_ENABLE_BIT];
      latch_only_select_r  <= S_AXI_WDATA[spfc_pkg::BIT_LATCH_ONLY_SELECT];
      config_space_select_r  <= S_AXI_WDATA[spfc_pkg::BIT_CONFIG_SPACE_SELECT];
      program_memory_select_r <= S_AXI_WDATA[spfc_pkg::BIT_PROGRAM_MEMORY_SELECT];
    end
  end

  // Erase select doubles as erase-busy flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      free_r <= 1'b0;
    end else if (ctrl_wr) begin
      free_r <= S_AXI_WDATA[spfc_pkg::BIT_FREE];
    end else if (op_done) begin
      free_r <= 1'b0;
    end
  end

  // Strobe status bits, set by software, cleared by hardware
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      rd_r <= start_rd || (rd_r && state_r != ST_RACC);
      wr_r <= (start_op && !start_latch) || (wr_r && !op_done);
    end
  end

  // Write latches
  generate
    for (genvar i = 0; i < spfc_pkg::LATCH_N; i++) begin : g_latch
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          latch_r[i] <= spfc_pkg::LATCH_ERASED;
        end else if (op_done && !free_r) begin
          latch_r[i] <= spfc_pkg::LATCH_ERASED;
        end else if (start_op && !free_r && lidx == 5'(i)) begin
          latch_r[i] <= {data_high_r, data_low_r};
        end
      end
      assign FLASH_BLOCK[i*14 +: 14] = latch_r[i];
    end
  endgenerate

  // Write response
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= spfc_pkg::RESP_OKAY;
    end else if (S_AXI_AWREADY) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (S_AXI_AWADDR > spfc_pkg::OFS_UNLOCK ||
                   S_AXI_AWADDR[1:0] != 2'h0) ?
                  spfc_pkg::RESP_SLVERR : spfc_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= spfc_pkg::RESP_OKAY;
    end else if (rd_acc) begin
      rvalid_r <= 1'b1;
      rresp_r  <= spfc_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        spfc_pkg::OFS_ADDR_LOW:  rdata_r <= {24'h0, addr_low_r};
        spfc_pkg::OFS_ADDR_HIGH: rdata_r <= {25'h0, addr_high_r};
        spfc_pkg::OFS_DATA_LOW:  rdata_r <= {24'h0, data_low_r};
        spfc_pkg::OFS_DATA_HIGH: rdata_r <= {26'h0, data_high_r};
        spfc_pkg::OFS_CONTROL:   rdata_r <= {24'h0, program_memory_select_r, config_space_select_r,
                                             latch_only_select_r, free_r, 1'b0,
                                             write_enable_bit_r, wr_r, rd_r};
        spfc_pkg::OFS_UNLOCK:    rdata_r <= 32'h0;
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= spfc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP  = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;

  // Checks
  sequence s_setup;
    !CORE_STALL ##1 !CORE_STALL;
  endsequence

  property p_rd_skip;
    @(posedge CLK_SYS) disable iff (RST)
      start_rd |=> !FLASH_RD ##1 (FLASH_RD && CORE_SKIP);
  endproperty
  a_rd_skip: assert property (p_rd_skip)
    else $error("Read access not in second cycle");

  property p_rd_data;
    @(posedge CLK_SYS) disable iff (RST)
      FLASH_RD |=> {data_high_r, data_low_r} == $past(FLASH_RDATA);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("Fetched word not in data pair");

  property p_rd_hold;
    @(posedge CLK_SYS) disable iff (RST)
      (!FLASH_RD && !wr_acc) |=> $stable({data_high_r, data_low_r});
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Data pair changed without cause");

  property p_write_enable_bit;
    @(posedge CLK_SYS) disable iff (RST)
      (wr_req && !write_enable_bit_r) |=> state_r == ST_IDLE && !wr_r;
  endproperty
  a_write_enable_bit: assert property (p_write_enable_bit)
    else $error("Write strobe taken without write enable");

  property p_unlock;
    @(posedge CLK_SYS) disable iff (RST)
      (wr_req && unlock_r != 2'd2) |=> !wr_r ##1 !CORE_STALL;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("Operation started without unlock");

  property p_setup;
    @(posedge CLK_SYS) disable iff (RST)
      (start_op && !start_latch) |=> s_setup ##1 CORE_STALL;
  endproperty
  a_setup: assert property (p_setup)
    else $error("Setup cycles wrong before stall");

  property p_latch_nostall;
    @(posedge CLK_SYS) disable iff (RST)
      start_latch |=> s_setup ##1 !CORE_STALL;
  endproperty
  a_latch_nostall: assert property (p_latch_nostall)
    else $error("Core stalled on latch load");

  property p_latch_reset;
    @(posedge CLK_SYS) disable iff (RST)
      (op_done && !free_r) |=> latch_r[0] == spfc_pkg::LATCH_ERASED &&
                               latch_r[31] == spfc_pkg::LATCH_ERASED;
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("Latches not reset after programming");

  property p_protect;
    @(posedge CLK_SYS) disable iff (RST)
      (wr_req && prot) |=> !wr_r;
  endproperty
  a_protect: assert property (p_protect)
    else $error("Operation started in protected segment");

  property p_no_auto_erase;
    @(posedge CLK_SYS) disable iff (RST)
      FLASH_PROG |-> !FLASH_ERASE && FLASH_ADDR[4:0] == 5'h00;
  endproperty
  a_no_auto_erase: assert property (p_no_auto_erase)
    else $error("Erase during program or unaligned block");

  property p_free_clear;
    @(posedge CLK_SYS) disable iff (RST)
      (op_done && free_r) |=> !free_r && !CORE_STALL;
  endproperty
  a_free_clear: assert property (p_free_clear)
    else $error("Erase completion not reported");

endmodule
`default_nettype wire

// ### logic/spfc_pkg.sv
// Constants shared by the self-programming flash controller
`default_nettype none
package spfc_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_ADDR_LOW   = 5'h00;
  localparam logic [4:0] OFS_ADDR_HIGH  = 5'h04;
  localparam logic [4:0] OFS_DATA_LOW   = 5'h08;
  localparam logic [4:0] OFS_DATA_HIGH  = 5'h0c;
  localparam logic [4:0] OFS_CONTROL    = 5'h10;
  localparam logic [4:0] OFS_UNLOCK     = 5'h14;
  // Control bit positions
  localparam int BIT_RD    = 0;
  localparam int BIT_WR    = 1;
  localparam int BIT_WRITE_ENABLE_BIT  = 2;
  localparam int BIT_FREE  = 4;
  localparam int BIT_LATCH_ONLY_SELECT  = 5;
  localparam int BIT_CONFIG_SPACE_SELECT  = 6;
  localparam int BIT_PROGRAM_MEMORY_SELECT = 7;
  // Widths
  localparam int ADDR_W   = 15;
  localparam int WORD_W   = 14;
  localparam int LATCH_N  = 32;
  localparam int LATCH_AW = 5;
  // Erased latch value and unlock keys
  localparam logic [13:0] LATCH_ERASED = 14'h3fff;
  localparam logic [7:0]  UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2  = 8'haa;
  // Write-protect field codes and protected upper bounds
  localparam logic [1:0]  WP_ALL       = 2'h0;
  localparam logic [1:0]  WP_LOWER     = 2'h1;
  localparam logic [1:0]  WP_BOOT      = 2'h2;
  localparam logic [14:0] WP_LOWER_END = 15'h07ff;
  localparam logic [14:0] WP_BOOT_END  = 15'h01ff;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_CYC     = 2;
  localparam int OP_TIME_NS    = 2000000;
  localparam int OP_CYC        = OP_TIME_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### testbench/self_program_flash_ctrl_tb.sv
// Self-checking bench for the self-programming flash controller
`timescale 1ns/10ps
`default_nettype none
module self_program_flash_ctrl_tb;
  localparam int OPC = 20;
  logic         clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, f_rd, f_erase;
  logic         f_prog, skip, stall, stall_q;
  logic [4:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, v;
  logic [1:0]   bresp, rresp, wp, resp;
  logic [14:0]  f_addr, rd_a, a;
  logic [13:0]  f_rdata, d1, d2, w;
  logic [447:0] f_block;
  int           miscompares = 0, n_compared = 0, seed = 50, cyc = 0;
  int           take_t = 0, skip_t = 0, stall_t = 0, n_stall = 0;
  int           n_prog = 0, n_erase = 0, s0, p0, e0, k, ok;

  spfc_ctrl #(.OP_CYC(OPC)) dut (
    .CLK_SYS(clk_sys), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WRITE_PROTECT_FIELD(wp), .FLASH_ADDR(f_addr), .FLASH_RD(f_rd),
    .FLASH_RDATA(f_rdata), .FLASH_ERASE(f_erase), .FLASH_PROG(f_prog),
    .FLASH_BLOCK(f_block), .CORE_SKIP(skip), .CORE_STALL(stall)
  );

  spfc_flash_model mdl (
    .clk(clk_sys), .addr(f_addr), .rd(f_rd), .rdata(f_rdata),
    .erase(f_erase), .prog(f_prog), .block(f_block)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [447:0] seen, input logic [447:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    $display("Error at %0t ns: wait ran out", $time);
    stop_test();
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  // Cycle stamps and pulse counters
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    stall_q <= stall;
    if (awvalid && awready === 1'b1 && awaddr == spfc_pkg::OFS_CONTROL &&
        wdata[1:0] != 2'h0) begin
      take_t <= cyc;
    end
    if (skip === 1'b1 && f_rd === 1'b1) begin
      skip_t <= cyc;
      rd_a <= f_addr;
    end
    if (stall === 1'b1) n_stall <= n_stall + 1;
    if (stall === 1'b1 && stall_q !== 1'b1) stall_t <= cyc;
    if (f_prog === 1'b1) n_prog <= n_prog + 1;
    if (f_erase === 1'b1) n_erase <= n_erase + 1;
    if (f_prog === 1'b1 || f_erase === 1'b1) begin
      chk(f_addr[4:0], 5'h0);
    end
  end

  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (awready !== 1'b1 && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    resp = bresp;
    if (n >= 100) tmo();
  endtask

  task automatic rd(input logic [4:0] ad, output logic [31:0] d);
    int n;
    @(posedge clk_sys);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
    if (n >= 100) tmo();
  endtask

  task automatic ctl(input logic [31:0] d);
    wr(spfc_pkg::OFS_CONTROL, d);
  endtask

  task automatic setaddr(input logic [14:0] ad);
    wr(spfc_pkg::OFS_ADDR_LOW, {24'h0, ad[7:0]});
    wr(spfc_pkg::OFS_ADDR_HIGH, {25'h0, ad[14:8]});
  endtask

  task automatic setdata(input logic [13:0] d);
    wr(spfc_pkg::OFS_DATA_LOW, {24'h0, d[7:0]});
    wr(spfc_pkg::OFS_DATA_HIGH, {26'h0, d[13:8]});
  endtask

  task automatic strobe(input logic [31:0] c);
    wr(spfc_pkg::OFS_UNLOCK, 32'h55);
    wr(spfc_pkg::OFS_UNLOCK, 32'haa);
    ctl(c);
  endtask

  task automatic waitidle(input logic [7:0] m);
    logic [31:0] c;
    int n;
    n = 0;
    do begin
      rd(spfc_pkg::OFS_CONTROL, c);
      n++;
    end while ((c[7:0] & m) !== 8'h0 && n < 200);
    if (n >= 200) tmo();
  endtask

  task automatic readw(input logic [14:0] ad, output logic [13:0] q);
    logic [31:0] lo, hi;
    setaddr(ad);
    ctl(32'h80);
    ctl(32'h81);
    waitidle(8'h01);
    chk(skip_t - take_t, 2);
    chk(rd_a, ad);
    rd(spfc_pkg::OFS_DATA_LOW, lo);
    rd(spfc_pkg::OFS_DATA_HIGH, hi);
    q = {hi[5:0], lo[7:0]};
  endtask

  function automatic logic [13:0] init_w(input logic [14:0] ad);
    return ad[13:0] ^ 14'h1234;
  endfunction

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    wp = 2'h3;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk(f_block, {448{1'b1}});
    for (int i = 0; i < 4; i++) begin
      a = 15'($random(seed));
      readw(a, w);
      chk(w, init_w(a));
    end
    wr(spfc_pkg::OFS_DATA_LOW, 32'h5a);
    rd(spfc_pkg::OFS_DATA_HIGH, v);
    chk(v[5:0], w[13:8]);
    rd(spfc_pkg::OFS_DATA_LOW, v);
    chk(v[7:0], 8'h5a);
    wr(5'h18, 32'h0);
    chk(resp, spfc_pkg::RESP_SLVERR);
    rd(5'h1c, v);
    chk(resp, spfc_pkg::RESP_SLVERR);
    done("read");
    a = 15'h0400 | {5'h0, 5'($random(seed)), 5'h0};
    setaddr(a + 15'd9);
    ctl(32'h90);
    e0 = n_erase;
    strobe(32'h92);
    repeat (OPC + 8) @(posedge clk_sys);
    chk(n_erase - e0, 0);
    ctl(32'h94);
    wr(spfc_pkg::OFS_UNLOCK, 32'haa);
    wr(spfc_pkg::OFS_UNLOCK, 32'h55);
    ctl(32'h96);
    wr(spfc_pkg::OFS_UNLOCK, 32'h55);
    wr(spfc_pkg::OFS_UNLOCK, 32'haa);
    setaddr(a + 15'd9);
    ctl(32'h96);
    repeat (OPC + 8) @(posedge clk_sys);
    chk(n_erase - e0, 0);
    done("refuse");
    for (int c = 0; c < 4; c++) begin
      wp <= 2'(c);
      e0 = n_erase;
      s0 = n_stall;
      ok = (c >= 2) ? 1 : 0;
      strobe(32'h96);
      if (ok == 1) waitidle(8'h12);
      else repeat (OPC + 8) @(posedge clk_sys);
      chk(n_erase - e0, ok);
      chk(n_stall - s0, ok * OPC);
    end
    chk(stall_t - take_t, 3);
    readw(a + 15'd31, w);
    chk(w, 14'h3fff);
    readw(a + 15'd32, w);
    chk(w, init_w(a + 15'd32));
    done("erase");
    ctl(32'ha4);
    k = {$random(seed)} % 31;
    d1 = 14'($random(seed));
    d2 = 14'($random(seed));
    setaddr(a + 15'(k));
    setdata(d1);
    s0 = n_stall;
    p0 = n_prog;
    strobe(32'ha6);
    repeat (OPC + 8) @(posedge clk_sys);
    chk(f_block[14*k +: 14], d1);
    chk(n_stall - s0 + n_prog - p0, 0);
    ctl(32'h84);
    setaddr(a + 15'd31);
    setdata(d2);
    strobe(32'h86);
    waitidle(8'h02);
    chk(n_prog - p0, 1);
    chk(n_stall - s0, OPC);
    chk(stall_t - take_t, 3);
    chk(f_block, {448{1'b1}});
    readw(a + 15'(k), w);
    chk(w, d1);
    readw(a + 15'd31, w);
    chk(w, d2);
    a = 15'h0800 | {5'h0, 5'($random(seed)), 5'h0};
    ctl(32'h84);
    setaddr(a + 15'd3);
    setdata(d1);
    strobe(32'h86);
    waitidle(8'h02);
    readw(a + 15'd3, w);
    chk(w, init_w(a + 15'd3) & d1);
    readw(a + 15'd32, w);
    chk(w, init_w(a + 15'd32));
    done("program");
    stop_test();
  end
endmodule
`default_nettype wire

// ### testbench/spfc_flash_model.sv
// Behavioural program flash array on the far side of the controller
`timescale 1ns/10ps
`default_nettype none
module spfc_flash_model (
  input  wire logic          clk,
  input  wire logic [14:0]   addr,
  input  wire logic          rd,
  output logic      [13:0]   rdata,
  input  wire logic          erase,
  input  wire logic          prog,
  input  wire logic [447:0]  block
);
  logic [13:0] mem [0:32767];
  logic [13:0] junk;

  initial begin
    junk = 14'h0;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 14'(i) ^ 14'h1234;
    end
  end

  // Word only during the access cycle, churning pattern otherwise
  assign rdata = rd ? mem[addr] : junk;

  always @(posedge clk) begin
    junk <= ~junk ^ 14'h0001;
    for (int i = 0; i < 32; i++) begin
      if (erase) begin
        mem[{addr[14:5], 5'(i)}] <= 14'h3fff;
      end
      if (prog) begin
        mem[{addr[14:5], 5'(i)}] <=
          mem[{addr[14:5], 5'(i)}] & block[14*i +: 14];
      end
    end
  end
endmodule
`default_nettype wire
